// ===== ams_pkg.sv
// Package: register map, mode and code word enumerations, timing constants
package ams_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_MODE     = 8'h04;
   localparam logic [7:0] ADDR_RANGE    = 8'h08;
   localparam logic [7:0] ADDR_RRATE    = 8'h0C;
   localparam logic [7:0] ADDR_PILOT    = 8'h10;
   localparam logic [7:0] ADDR_LIMITS   = 8'h14;
   localparam logic [7:0] ADDR_SENSOR   = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;
   localparam logic [7:0] ADDR_KICK     = 8'h28;
   // ==========================================================
   // Control register bit positions
   localparam int CTRL_ENGAGE  = 0;
   localparam int CTRL_CLEAR   = 1;
   localparam int CTRL_FAULTBT = 2;
   localparam int CTRL_SYSFAIL = 3;
   localparam int CTRL_OVERSH  = 4;
   localparam int CTRL_IOFAIL  = 5;
   localparam int CTRL_PWRLOSS = 6;
   // ==========================================================
   // Interlock and test figures
   localparam logic [15:0] RANGE_MIN_FT   = 16'd1000;
   localparam logic [15:0] RRATE_MIN_KT   = 16'd50;
   localparam logic [2:0]  SUBST_CYCLES   = 3'd5;
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          TEST_PERIOD_MS = 1000;
   localparam int          TEST_CYCLES    = CLK_HZ / 1000 * TEST_PERIOD_MS;
   localparam int          WDOG_MS        = 100;
   localparam int          WDOG_CYCLES    = CLK_HZ / 1000 * WDOG_MS;
   localparam int          PWRUP_US       = 10;
   localparam int          PWRUP_CYCLES   = CLK_HZ / 1_000_000 * PWRUP_US;
   localparam int          NUM_SENSORS    = 8;
   // ==========================================================
   typedef enum logic [2:0] {
      MODE_STANDBY,
      MODE_COMPUTE,
      MODE_FAULT_LAMP,
      MODE_PWRUP
   } ams_mode_t;
   typedef enum logic [2:0] {
      CODE_READOUT,
      CODE_ALLSEG,
      CODE_DATA,
      CODE_FLAG,
      CODE_FAIL,
      CODE_FAST,
      CODE_BLANK
   } ams_code_t;
   // Interrupt status bits
   localparam int IRQ_FAULT_LAMP     = 0;
   localparam int IRQ_COMPLETE = 1;
   localparam int IRQ_SUBST    = 2;
   localparam int IRQ_WIDTH    = 3;
endpackage

// ===== ams_sensor_check.sv
// Per-sensor validity and substitution counters
`timescale 1ns/1ps
`default_nettype none
module ams_sensor_check #(
   parameter int N = ams_pkg::NUM_SENSORS
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         tick,
   input  wire logic [N-1:0] bad,
   output logic [N-1:0]      subst_q,
   output logic              expired_q
);
   initial begin
      if (N < 1 || N > 32) $error("ams_sensor_check: N out of range");
   end
   logic [2:0] cnt_q [N];
   logic [N-1:0] exp_w;
   // ==========================================================
   // Counting
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < N; i++) begin
         if (sys_rst || !bad[i]) begin
            cnt_q[i] <= 3'h0;
         end else if (tick && cnt_q[i] <= ams_pkg::SUBST_CYCLES) begin
            cnt_q[i] <= cnt_q[i] + 3'h1;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < N; i++) begin
         exp_w[i] = cnt_q[i] > ams_pkg::SUBST_CYCLES;
      end
   end
   // Substitution holds only within six bad cycles
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         subst_q   <= '0;
         expired_q <= 1'b0;
      end else begin
         subst_q   <= bad & ~exp_w; // see RULE9
         expired_q <= |exp_w;       // see RULE10
      end
   end
endmodule
`default_nettype wire

// ===== ams_supervisor.sv
// Approach mode supervisor top with Wishbone registers
// Contract
// RULE1 - Leaving compute goes to standby or inoperative according to cause
// RULE2 - On disengage hide fast/slow marker, blank lamps and numeric displays
// RULE3 - In inoperative, fault button or clear returns standby, lamp off
// RULE4 - Range below 1000 ft completes approach: standby, lamp off, readout
// RULE5 - Go-around selection breaks interlock: standby, lamp off
// RULE6 - Range not closing above 50 knots: inoperative, lamp on, all segments
// RULE7 - Pilot value outside limits: inoperative, lamp on, data code
// RULE8 - Check sensor flags, transducer validity and reasonableness of every sensor
// RULE9 - Substitute data for a single bad sensor up to 5 cycles; the code substitutes for up to six bad cycles
// RULE10 - Sensor bad beyond 5 cycles: inoperative, lamp on, flag code; the code goes inoperative only after six bad cycles
// RULE11 - Power loss walks inoperative, power-up, standby; lamp on, blank message
// RULE12 - Lockup forces inoperative by an independent watchdog
// RULE13 - Selector test position exercises all drivers and displays
// RULE14 - Test converter and transmitter units
// RULE15 - System failure gives fail code, overshoot gives fast code, lamp on
// RULE16 - In compute repeat all tests at least once per second
// RULE17 - Any failed periodic test disengages compute immediately
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ams_supervisor #(
   parameter int N            = ams_pkg::NUM_SENSORS,
   parameter int TEST_CYCLES  = ams_pkg::TEST_CYCLES,
   parameter int WDOG_CYCLES  = ams_pkg::WDOG_CYCLES,
   parameter int PWRUP_CYCLES = ams_pkg::PWRUP_CYCLES
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         go_around_pin,
   input  wire logic         test_sel_pin,
   input  wire logic         clear_btn_pin,
   input  wire logic         fault_btn_pin,
   input  wire logic [N-1:0] sensor_flag_pin,
   output logic              fault_lamp,
   output logic              marker_show,
   output logic              flap_lamp,
   output logic              gear_lamp,
   output logic              thrust_ratio_lamp,
   output logic              display_on,
   output logic [2:0]        code_word,
   output logic [N-1:0]      subst_active,
   output logic              test_drive,
   output logic              irq
);
   initial begin
      if (TEST_CYCLES < 1 || TEST_CYCLES > ams_pkg::TEST_CYCLES)
         $error("ams_supervisor: TEST_CYCLES out of range");
      if (WDOG_CYCLES < 2 || PWRUP_CYCLES < 1)
         $error("ams_supervisor: timing parameters too small");
   end
   // ==========================================================
   // Pin synchronisers
   logic [4+N-1:0] s1_q, s2_q;
   always_ff @(posedge core_clk) begin
      s1_q <= {go_around_pin, test_sel_pin, clear_btn_pin, fault_btn_pin, sensor_flag_pin};
      s2_q <= s1_q;
   end
   logic go_around, test_sel, clear_btn, fault_btn;
   logic [N-1:0] sflag;
   assign {go_around, test_sel, clear_btn, fault_btn, sflag} = s2_q;
   // ==========================================================
   // Registers
   logic [6:0]  ctrl_q;
   logic [15:0] range_q, rrate_q, pilot_q, lim_lo_q, lim_hi_q;
   logic        closing_q;
   logic [N-1:0] sens_bad_q;
   localparam int IRQW = ams_pkg::IRQ_WIDTH;
   logic [IRQW-1:0] stat_q, en_q;
   logic [N-1:0] subst_q;
   logic        kick_q;
   ams_pkg::ams_mode_t mode_q;
   ams_pkg::ams_code_t code_q;
   logic wr, rd;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q     <= 7'h00;
         range_q    <= 16'hFFFF;
         rrate_q    <= 16'h0000;
         closing_q  <= 1'b0;
         pilot_q    <= 16'h0000;
         lim_lo_q   <= 16'h0000;
         lim_hi_q   <= 16'hFFFF;
         sens_bad_q <= '0;
         en_q       <= '0;
         kick_q     <= 1'b0;
      end else begin
         kick_q <= wr && wb_adr_i == ams_pkg::ADDR_KICK;
         // Command bits are one-shot; engage clears once compute is entered
         ctrl_q[6:1] <= '0;
         if (mode_q == ams_pkg::MODE_COMPUTE) ctrl_q[ams_pkg::CTRL_ENGAGE] <= 1'b0;
         if (wr) begin
            case (wb_adr_i)
               ams_pkg::ADDR_CTRL: begin
                  if (wb_sel_i[0]) ctrl_q <= wb_dat_i[6:0];
               end
               ams_pkg::ADDR_RANGE: range_q <= merge16(range_q, wb_dat_i, wb_sel_i);
               ams_pkg::ADDR_RRATE: begin
                  rrate_q <= merge16(rrate_q, wb_dat_i, wb_sel_i);
                  if (wb_sel_i[2]) closing_q <= wb_dat_i[16];
               end
               ams_pkg::ADDR_PILOT: pilot_q <= merge16(pilot_q, wb_dat_i, wb_sel_i);
               ams_pkg::ADDR_LIMITS: begin
                  lim_lo_q <= merge16(lim_lo_q, wb_dat_i, wb_sel_i);
                  lim_hi_q <= merge16(lim_hi_q, {16'h0000, wb_dat_i[31:16]},
                                      {2'b00, wb_sel_i[3:2]});
               end
               ams_pkg::ADDR_SENSOR: sens_bad_q <= wb_dat_i[N-1:0];
               ams_pkg::ADDR_IRQ_EN: en_q <= wb_dat_i[IRQW-1:0];
               default: ;
            endcase
         end
      end
   end
   // ==========================================================
   // Bus answer: one wait-free cycle, unmapped reads as zero
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wr || rd;
         wb_dat_o <= 32'h0000_0000;
         if (rd) begin
            case (wb_adr_i)
               ams_pkg::ADDR_CTRL:     wb_dat_o <= {25'h0, ctrl_q};
               ams_pkg::ADDR_MODE:     wb_dat_o <= {16'h0, 5'h0, code_q, 5'h0, mode_q};
               ams_pkg::ADDR_RANGE:    wb_dat_o <= {16'h0, range_q};
               ams_pkg::ADDR_RRATE:    wb_dat_o <= {15'h0, closing_q, rrate_q};
               ams_pkg::ADDR_PILOT:    wb_dat_o <= {16'h0, pilot_q};
               ams_pkg::ADDR_LIMITS:   wb_dat_o <= {lim_hi_q, lim_lo_q};
               ams_pkg::ADDR_SENSOR:   wb_dat_o <= 32'(subst_q);
               ams_pkg::ADDR_IRQ_STAT: wb_dat_o <= 32'(stat_q);
               ams_pkg::ADDR_IRQ_EN:   wb_dat_o <= 32'(en_q);
               default:                wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // ==========================================================
   // Periodic test tick and lockup watchdog
   logic [31:0] tcnt_q, wdog_q;
   logic tick;
   assign tick = tcnt_q == 32'(TEST_CYCLES - 1);
   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q != ams_pkg::MODE_COMPUTE || tick) tcnt_q <= 32'h0; // see RULE16
      else tcnt_q <= tcnt_q + 32'h1;
   end
   // Software must kick; a stuck processor cannot, so the counter expires alone
   always_ff @(posedge core_clk) begin
      if (sys_rst || kick_q || mode_q != ams_pkg::MODE_COMPUTE) wdog_q <= 32'h0;
      else if (wdog_q != 32'(WDOG_CYCLES)) wdog_q <= wdog_q + 32'h1;
   end
   logic lockup;
   assign lockup = wdog_q == 32'(WDOG_CYCLES); // see RULE12
   // ==========================================================
   // Sensor checking: pin flags plus software reasonableness verdicts
   logic         sens_exp;
   ams_sensor_check #(.N(N)) u_sens (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .tick      (1'b1),
      .bad       (sflag | sens_bad_q), // see RULE8
      .subst_q   (subst_q),
      .expired_q (sens_exp)
   );
   // ==========================================================
   // Causes; the mode machine ranks them, range and go-around first, then fail, slow last
   logic thr, ga, slow, pdat, fail, fast;
   assign thr  = range_q < ams_pkg::RANGE_MIN_FT; // see RULE4
   assign ga   = go_around;                       // see RULE5
   assign slow = !closing_q || rrate_q <= ams_pkg::RRATE_MIN_KT; // see RULE6
   assign pdat = pilot_q < lim_lo_q || pilot_q > lim_hi_q;       // see RULE7
   assign fail = ctrl_q[ams_pkg::CTRL_SYSFAIL] || ctrl_q[ams_pkg::CTRL_IOFAIL] || lockup; // see RULE14
   assign fast = ctrl_q[ams_pkg::CTRL_OVERSH];
   logic [31:0] pcnt_q;
   logic pwr_loss;
   assign pwr_loss = ctrl_q[ams_pkg::CTRL_PWRLOSS];
   // ==========================================================
   // Mode machine
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_q <= ams_pkg::MODE_FAULT_LAMP; // see RULE11
         code_q <= ams_pkg::CODE_BLANK;
         pcnt_q <= 32'h0;
      end else if (pwr_loss) begin
         mode_q <= ams_pkg::MODE_FAULT_LAMP; // see RULE11
         code_q <= ams_pkg::CODE_BLANK;
      end else begin
         case (mode_q)
            ams_pkg::MODE_STANDBY: begin
               if (ctrl_q[ams_pkg::CTRL_ENGAGE]) mode_q <= ams_pkg::MODE_COMPUTE;
            end
            ams_pkg::MODE_COMPUTE: begin
               // Any failing check leaves compute on this same edge
               if (clear_btn || ctrl_q[ams_pkg::CTRL_CLEAR] || thr || ga) begin // see RULE17
                  mode_q <= ams_pkg::MODE_STANDBY; // see RULE1
                  code_q <= ams_pkg::CODE_READOUT;
               end else if (fail || fast || pdat || sens_exp || slow) begin
                  mode_q <= ams_pkg::MODE_FAULT_LAMP; // see RULE1
                  if (fail) code_q <= ams_pkg::CODE_FAIL;            // see RULE15
                  else if (fast) code_q <= ams_pkg::CODE_FAST;       // see RULE15
                  else if (pdat) code_q <= ams_pkg::CODE_DATA;       // see RULE7
                  else if (sens_exp) code_q <= ams_pkg::CODE_FLAG;   // see RULE10
                  else code_q <= ams_pkg::CODE_ALLSEG;               // see RULE6
               end
            end
            ams_pkg::MODE_FAULT_LAMP: begin
               if (code_q == ams_pkg::CODE_BLANK) begin
                  mode_q <= ams_pkg::MODE_PWRUP; // see RULE11
                  pcnt_q <= 32'h0;
               end else if (fault_btn || clear_btn || ctrl_q[ams_pkg::CTRL_FAULTBT] ||
                            ctrl_q[ams_pkg::CTRL_CLEAR]) begin
                  mode_q <= ams_pkg::MODE_STANDBY; // see RULE3
                  code_q <= ams_pkg::CODE_READOUT;
               end
            end
            ams_pkg::MODE_PWRUP: begin
               pcnt_q <= pcnt_q + 32'h1;
               if (pcnt_q == 32'(PWRUP_CYCLES - 1)) begin
                  mode_q <= ams_pkg::MODE_STANDBY; // see RULE11
                  code_q <= ams_pkg::CODE_READOUT;
               end
            end
            default: mode_q <= ams_pkg::MODE_FAULT_LAMP;
         endcase
      end
   end
   // ==========================================================
   // Interrupts: set wins over clear
   logic [IRQW-1:0] ev;
   logic [IRQW-1:0] clr;
   assign ev[ams_pkg::IRQ_FAULT_LAMP]     = mode_q == ams_pkg::MODE_COMPUTE && !pwr_loss &&
                                      (fail || fast || pdat || sens_exp || slow) &&
                                      !(clear_btn || ctrl_q[ams_pkg::CTRL_CLEAR] || thr || ga);
   assign ev[ams_pkg::IRQ_COMPLETE] = mode_q == ams_pkg::MODE_COMPUTE && (thr || ga);
   assign ev[ams_pkg::IRQ_SUBST]    = |subst_q;
   assign clr = (wr && wb_adr_i == ams_pkg::ADDR_IRQ_CLR) ? wb_dat_i[IRQW-1:0] : '0;
   always_ff @(posedge core_clk) begin
      if (sys_rst) stat_q <= '0;
      else stat_q <= (stat_q & ~clr) | ev;
   end
   // ==========================================================
   // Outputs; test position lights everything
   logic comp;
   assign comp = mode_q == ams_pkg::MODE_COMPUTE;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fault_lamp        <= 1'b1;
         marker_show       <= 1'b0;
         flap_lamp         <= 1'b0;
         gear_lamp         <= 1'b0;
         thrust_ratio_lamp <= 1'b0;
         display_on        <= 1'b0;
         code_word         <= 3'h0;
         subst_active      <= '0;
         test_drive        <= 1'b0;
         irq               <= 1'b0;
      end else begin
         fault_lamp        <= test_sel || mode_q == ams_pkg::MODE_FAULT_LAMP ||
                              mode_q == ams_pkg::MODE_PWRUP; // see RULE13
         marker_show       <= test_sel || comp; // see RULE2
         flap_lamp         <= test_sel || comp; // see RULE2
         gear_lamp         <= test_sel || comp; // see RULE2
         thrust_ratio_lamp <= test_sel || comp; // see RULE2
         display_on        <= test_sel || comp; // see RULE2
         code_word         <= test_sel ? ams_pkg::CODE_ALLSEG : code_q; // see RULE13
         subst_active      <= subst_q;
         test_drive        <= test_sel; // see RULE13
         irq               <= |(stat_q & en_q);
      end
   end
endmodule
`default_nettype wire

// ===== ams_panel_model.sv
// Model of the pilot panel and the aircraft sensor flags in front of the supervisor
`timescale 1ns/1ps
`default_nettype none
module ams_panel_model (
   input  wire logic       core_clk,
   input  wire logic [3:0] press,
   input  wire logic [7:0] bad,
   output logic            go_around_pin,
   output logic            test_sel_pin,
   output logic            clear_btn_pin,
   output logic            fault_btn_pin,
   output logic [7:0]      sensor_flag_pin
);
   // ==========================================================
   // Switches and flags
   // Contacts move only just after an edge, so no pin changes inside a sampling window
   always_ff @(posedge core_clk) begin
      {go_around_pin, test_sel_pin, clear_btn_pin, fault_btn_pin} <= press;
      sensor_flag_pin <= bad;
   end
endmodule
`default_nettype wire

// ===== ams_supervisor_asserts.sv
// Checker on the ports of the approach mode supervisor
`timescale 1ns/1ps
`default_nettype none
module ams_supervisor_asserts #(
   parameter int N = ams_pkg::NUM_SENSORS
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic [31:0]  wb_dat_o,
   input  wire logic         wb_ack_o,
   input  wire logic         go_around_pin,
   input  wire logic         clear_btn_pin,
   input  wire logic         fault_lamp,
   input  wire logic         marker_show,
   input  wire logic         flap_lamp,
   input  wire logic         gear_lamp,
   input  wire logic         thrust_ratio_lamp,
   input  wire logic         display_on,
   input  wire logic [2:0]   code_word,
   input  wire logic [N-1:0] subst_active,
   input  wire logic         test_drive
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [4:0] subst_run_q;
   // ==========================================================
   // Run of substitution cycles, saturating so it never wraps back under the limit
   always_ff @(posedge core_clk) begin
      if (sys_rst || subst_active == '0) begin
         subst_run_q <= 5'h00;
      end else if (subst_run_q != 5'h1F) begin
         subst_run_q <= subst_run_q + 5'h01;
      end
   end
   // ==========================================================
   // Properties
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data without ack");
   a_disengage_blank:
      assert property (!marker_show && !test_drive && !$past(test_drive)
         |-> !flap_lamp && !gear_lamp && !thrust_ratio_lamp && !display_on)
      else $error("lamps lit outside compute");
   a_error_lamp_on:
      assert property (code_word inside {[3'h1:3'h5]} && !test_drive && !$past(test_drive)
         |-> fault_lamp)
      else $error("error code without fault lamp");
   a_blank_lamp_on:
      assert property (code_word == ams_pkg::CODE_BLANK && !test_drive && !$past(test_drive)
         |-> fault_lamp && !display_on)
      else $error("blank code with lamp off or display on");
   a_clear_standby:
      assert property ($rose(clear_btn_pin) && fault_lamp && !test_drive
         && code_word != ams_pkg::CODE_BLANK |-> ##[2:8] !fault_lamp)
      else $error("clear left fault lamp on");
   a_goaround_exit:
      assert property ($rose(go_around_pin) && marker_show |-> ##[2:8] !marker_show && !fault_lamp)
      else $error("go-around did not leave compute");
   a_subst_brief:
      assert property ($rose(subst_active != '0) && marker_show |=> marker_show [*2])
      else $error("substitution dropped compute at once");
   a_subst_limit:
      assert property (subst_run_q >= 5'h0A |-> !marker_show)
      else $error("substitution ran too long in compute");
   a_test_drivers:
      assert property (test_drive [*2] |-> display_on && flap_lamp && gear_lamp && thrust_ratio_lamp)
      else $error("test position left a driver off");
endmodule
bind ams_supervisor ams_supervisor_asserts #(.N(N)) i_ams_supervisor_asserts (.*);
`default_nettype wire

// ===== ams_supervisor_bench.sv
// Self-checking bench for the approach mode supervisor
`timescale 1ns/1ps
`default_nettype none
module ams_supervisor_bench;
   logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, pu_seen;
   logic        go_around_pin, test_sel_pin, clear_btn_pin, fault_btn_pin, fault_lamp;
   logic        marker_show, flap_lamp, gear_lamp, thrust_ratio_lamp, display_on, test_drive;
   logic        blank_seen;
   logic [2:0]  code_word;
   logic [3:0]  wb_sel_i, press;
   logic [7:0]  wb_adr_i, bad, sensor_flag_pin, subst_active, seen;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   int          errors, checked;
   // ==========================================================
   // Clock, design and panel
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Short counts keep the run small; expectations below follow these values
   ams_supervisor #(.TEST_CYCLES(16), .WDOG_CYCLES(64), .PWRUP_CYCLES(8)) i_ams_supervisor (.*);
   ams_panel_model i_ams_panel_model (.*);
   always @(posedge core_clk) begin
      if (code_word === ams_pkg::CODE_BLANK && fault_lamp === 1'b1) blank_seen <= 1'b1;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      chk("ack", 32'h1, 32'(wb_ack_o));
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // Idle cycle so the next request never lands in the release time step
      @(posedge core_clk);
   endtask
   task automatic expect_mode(input logic [2:0] m, input logic [2:0] c, input logic lamp);
      wb(1'b0, 8'h04, 32'h0);
      chk("mode", 32'(m), 32'(q[2:0]));
      if (c != 3'h7) chk("code", 32'(c), 32'(q[10:8]));
      chk("fault_lamp", 32'(lamp), 32'(fault_lamp));
   endtask
   task automatic arm();
      wb(1'b1, 8'h00, 32'h2);
      wb(1'b1, 8'h28, 32'h0);
      wb(1'b1, 8'h18, 32'h0);
      wb(1'b1, 8'h08, 32'h2000);
      wb(1'b1, 8'h0C, 32'h10064);
      wb(1'b1, 8'h14, 32'h2000010);
      wb(1'b1, 8'h10, 32'h100);
      wb(1'b1, 8'h00, 32'h1);
      repeat (4) @(posedge core_clk);
      expect_mode(3'h1, 3'h7, 1'b0);
      chk("marker", 32'h1, 32'(marker_show));
   endtask
   task automatic cause(input logic [7:0] a, input logic [31:0] d, input logic [2:0] m,
                        input logic [2:0] c, input logic l);
      arm();
      wb(1'b1, a, d);
      repeat (6) @(posedge core_clk);
      expect_mode(m, c, l);
      chk("blanked", 32'h0, 32'({marker_show, flap_lamp, gear_lamp, thrust_ratio_lamp,
                                  display_on}));
   endtask
   task automatic print_verdict();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      print_verdict();
   end
   // ==========================================================
   // Tests
   initial begin
      {errors, checked} = 64'h0;
      {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, blank_seen} = 5'h10;
      {wb_adr_i, wb_dat_i, press, bad} = 52'h0;
      wb_sel_i = 4'hF;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (16) @(posedge core_clk);
      chk("blank seen", 32'h1, 32'(blank_seen));
      expect_mode(3'h0, 3'h0, 1'b0);
      wb(1'b0, 8'h08, 32'h0);
      chk("range reset", 32'h0000_FFFF, q);
      $display("test startup done");
      cause(8'h08, 32'h3E7, 3'h0, 3'h0, 1'b0);
      cause(8'h0C, 32'h10032, 3'h2, 3'h1, 1'b1);
      cause(8'h0C, 32'h64, 3'h2, 3'h1, 1'b1);
      cause(8'h10, 32'h201, 3'h2, 3'h2, 1'b1);
      cause(8'h10, 32'hF, 3'h2, 3'h2, 1'b1);
      cause(8'h00, 32'h8, 3'h2, 3'h4, 1'b1);
      cause(8'h00, 32'h10, 3'h2, 3'h5, 1'b1);
      cause(8'h00, 32'h20, 3'h2, 3'h4, 1'b1);
      cause(8'h18, 32'h1, 3'h2, 3'h3, 1'b1);
      cause(8'h00, 32'h2, 3'h0, 3'h0, 1'b0);
      $display("test disengage causes done");
      wb(1'b1, 8'h20, 32'h7);
      wb(1'b1, 8'h24, 32'h1);
      chk("irq idle", 32'h0, 32'(irq));
      cause(8'h0C, 32'h10000, 3'h2, 3'h1, 1'b1);
      chk("irq", 32'h1, 32'(irq));
      wb(1'b0, 8'h1C, 32'h0);
      chk("irq status", 32'h1, q & 32'h1);
      wb(1'b1, 8'h24, 32'h0000_0000);
      chk("irq masked", 32'h0, 32'(irq));
      wb(1'b1, 8'h24, 32'h0000_0001);
      wb(1'b1, 8'h20, 32'h0000_0001);
      chk("irq cleared", 32'h0, 32'(irq));
      wb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test interrupt done");
      arm();
      press[3] <= 1'b1;
      repeat (10) @(posedge core_clk);
      expect_mode(3'h0, 3'h0, 1'b0);
      press[3] <= 1'b0;
      arm();
      seen = 8'h00;
      bad <= 8'h04;
      // Five bad cycles is the longest run that must still ride on substitutes
      for (int i = 0; i < 12; i++) begin
         @(posedge core_clk);
         seen = seen | subst_active;
         if (i == 4) bad <= 8'h00;
      end
      chk("substituted", 32'h04, 32'(seen));
      expect_mode(3'h1, 3'h7, 1'b0);
      arm();
      bad <= 8'h01;
      repeat (14) @(posedge core_clk);
      bad <= 8'h00;
      expect_mode(3'h2, 3'h3, 1'b1);
      press[0] <= 1'b1;
      repeat (8) @(posedge core_clk);
      press[0] <= 1'b0;
      expect_mode(3'h0, 3'h0, 1'b0);
      $display("test pins and sensors done");
      arm();
      repeat (80) @(posedge core_clk);
      expect_mode(3'h2, 3'h4, 1'b1);
      press[1] <= 1'b1;
      repeat (8) @(posedge core_clk);
      press[1] <= 1'b0;
      expect_mode(3'h0, 3'h0, 1'b0);
      press[2] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("drivers", 32'h1F, 32'({test_drive, display_on, flap_lamp, gear_lamp,
                                  thrust_ratio_lamp}));
      press[2] <= 1'b0;
      repeat (4) @(posedge core_clk);
      $display("test lockup and selector done");
      arm();
      {blank_seen, pu_seen} = 2'h0;
      wb(1'b1, 8'h00, 32'h0000_0040);
      repeat (6) begin
         wb(1'b0, 8'h04, 32'h0);
         if (q[2:0] === 3'h3) pu_seen = 1'b1;
      end
      chk("power-up seen", 32'h1, 32'(pu_seen));
      chk("blank seen", 32'h1, 32'(blank_seen));
      expect_mode(3'h0, 3'h0, 1'b0);
      $display("test power loss done");
      print_verdict();
   end
endmodule
`default_nettype wire
